// ### core/spd_pkg.sv
`default_nettype none
package spd_pkg;
  // ==========================================
  // timing figures and cycle counts (25 MHz clock)
  localparam int CLK_PERIOD_PS = 40000;
  localparam int HOLD_AFTER_ENTRY_PS = 5000;
  localparam int HOLD_AFTER_ENTRY_NCK = 5;
  localparam int MIN_PULSE_PS = 7500;
  localparam int MIN_PULSE_NCK = 4;
  localparam int EXIT_LATENCY_PS = 7500;
  localparam int EXIT_LATENCY_NCK = 5;
  // least times round up, at least one cycle
  localparam int HOLD_PS_CYC = (HOLD_AFTER_ENTRY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_PS_CYC = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXIT_PS_CYC = (EXIT_LATENCY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;
  // ==========================================
  // axi4-lite register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TERM = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TERM_RESET = 32'h0000_0000;
  localparam int CTRL_BANKS_OPEN_BIT = 0;
  localparam int CTRL_SELF_REFRESH_BIT = 1;
  localparam int CTRL_OPS_BUSY_BIT = 2;
  localparam int CTRL_EXT_TERM_BIT = 3;
  localparam int CTRL_IO_SUPPLY_OK_BIT = 4;
  localparam int TERM_LO = 4;
  localparam int TERM_HI = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================
  // power-down variants
  typedef enum logic [2:0] {
    PD_NONE = 3'b001,
    PD_IDLE = 3'b010,
    PD_ACTIVE = 3'b100
  } spd_variant_t;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_DOWN = 4'b0100,
    ST_EXIT = 4'b1000
  } spd_state_t;
endpackage : spd_pkg
`default_nettype wire

// ### core/spd_power_down.sv
// Overview of operation
// - enter power-down when clock-enable falls
// - finish activate/precharge/refresh before low current
// - entry deactivates buffers except enable, reset
// - receivers off after clock hold window
// - no refresh unless self-refresh power-down
// - exit when clock-enable rises, minimum pulse not enforced
// - idle, active, self-refresh variants by entry
// - command bus termination kept during power-down
`timescale 1ns/100ps
`default_nettype none
module spd_power_down (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cke_pin,
  input wire logic ck_pin,
  input wire logic cs_pin,
  input wire logic [5:0] command_address_bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic power_down,
  output logic buffers_off,
  output logic receivers_off,
  output logic low_current,
  output logic refresh_run,
  output logic ca_term_on,
  output logic cmd_ready,
  output logic [5:0] cmd_q,
  output logic cmd_valid
);
  // ==========================================
  // pin synchronisers
  logic [2:0] cke_s_q, cke_s_d;
  logic [2:0] ck_s_q, ck_s_d;
  logic [1:0] cs_s_q, cs_s_d;
  logic [5:0] ca_s1_q, ca_s2_q;
  logic cke;
  logic ck_rise;
  always_comb begin
    cke_s_d = {cke_s_q[1:0], cke_pin};
    ck_s_d = {ck_s_q[1:0], ck_pin};
    cs_s_d = {cs_s_q[0], cs_pin};
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cke_s_q <= 3'h7; // idle level high, else false entry after reset
      ck_s_q <= 3'h0;
      cs_s_q <= 2'h0;
      ca_s1_q <= 6'h00;
      ca_s2_q <= 6'h00;
    end else begin
      cke_s_q <= cke_s_d;
      ck_s_q <= ck_s_d;
      cs_s_q <= cs_s_d;
      ca_s1_q <= command_address_bus;
      ca_s2_q <= ca_s1_q;
    end
  end
  assign cke = cke_s_q[1];
  assign ck_rise = ck_s_q[1] & ~ck_s_q[2];
  // ==========================================
  // register file
  logic [31:0] ctrl_q, ctrl_d, term_q, term_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_w;
  logic [31:0] wmask;
  logic do_write;
  spd_pkg::spd_state_t st_q, st_d;
  spd_pkg::spd_variant_t var_q, var_d;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    term_d = term_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    wmask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = (wdata_q & ~wmask) | (s_axi_wdata & wmask);
    end
    do_write = aw_hold_q && w_hold_q && !bvalid_q;
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = spd_pkg::RESP_OKAY;
      case (awaddr_q)
        spd_pkg::ADDR_CTRL: ctrl_d = wdata_q;
        spd_pkg::ADDR_TERM: term_d = wdata_q;
        spd_pkg::ADDR_STATUS: bresp_d = spd_pkg::RESP_OKAY;
        default: bresp_d = spd_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = spd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        spd_pkg::ADDR_CTRL: rdata_d = ctrl_q;
        spd_pkg::ADDR_STATUS: rdata_d = status_w;
        spd_pkg::ADDR_TERM: rdata_d = term_q;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = spd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      ctrl_q <= spd_pkg::CTRL_RESET;
      term_q <= spd_pkg::TERM_RESET;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      term_q <= term_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  // ==========================================
  // power-down state machine
  logic [spd_pkg::CNT_W-1:0] ns_q, ns_d, nck_q, nck_d;
  logic hold_done;
  assign hold_done = (ns_q >= spd_pkg::CNT_W'(spd_pkg::HOLD_PS_CYC))
    && (nck_q >= spd_pkg::CNT_W'(spd_pkg::HOLD_AFTER_ENTRY_NCK));
  always_comb begin
    st_d = st_q;
    var_d = var_q;
    ns_d = ns_q;
    nck_d = nck_q;
    if (ns_q != {spd_pkg::CNT_W{1'b1}}) ns_d = ns_q + 1'b1;
    if (ck_rise && nck_q != {spd_pkg::CNT_W{1'b1}}) nck_d = nck_q + 1'b1;
    case (st_q)
      spd_pkg::ST_RUN: begin
        if (!cke) begin
          st_d = spd_pkg::ST_HOLD;
          ns_d = '0;
          nck_d = '0;
          // variant frozen at entry
          if (ctrl_q[spd_pkg::CTRL_SELF_REFRESH_BIT]) var_d = spd_pkg::PD_NONE;
          else if (ctrl_q[spd_pkg::CTRL_BANKS_OPEN_BIT]) var_d = spd_pkg::PD_ACTIVE;
          else var_d = spd_pkg::PD_IDLE;
        end
      end
      spd_pkg::ST_HOLD: begin
        if (cke) begin
          st_d = spd_pkg::ST_EXIT;
          ns_d = '0;
          nck_d = '0;
        end else if (hold_done) begin
          st_d = spd_pkg::ST_DOWN;
        end
      end
      spd_pkg::ST_DOWN: begin
        if (cke) begin
          st_d = spd_pkg::ST_EXIT;
          ns_d = '0;
          nck_d = '0;
        end
      end
      spd_pkg::ST_EXIT: begin
        if (!cke) begin
          st_d = spd_pkg::ST_HOLD;
          ns_d = '0;
          nck_d = '0;
        end else if (ns_q >= spd_pkg::CNT_W'(spd_pkg::EXIT_PS_CYC)
            && nck_q >= spd_pkg::CNT_W'(spd_pkg::EXIT_LATENCY_NCK)) begin
          st_d = spd_pkg::ST_RUN;
        end
      end
      default: st_d = spd_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= spd_pkg::ST_RUN;
      var_q <= spd_pkg::PD_NONE;
      ns_q <= '0;
      nck_q <= '0;
    end else begin
      st_q <= st_d;
      var_q <= var_d;
      ns_q <= ns_d;
      nck_q <= nck_d;
    end
  end
  // ==========================================
  // command capture and power outputs
  logic [5:0] cmd_d, cmd_r_q;
  logic cmd_valid_d, cmd_valid_q;
  always_comb begin
    cmd_d = cmd_r_q;
    cmd_valid_d = 1'b0;
    // inputs other than enable, reset ignored while down
    if (st_q == spd_pkg::ST_RUN && cke && cs_s_q[1] && ck_rise) begin
      cmd_d = ca_s2_q;
      cmd_valid_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cmd_r_q <= 6'h00;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_r_q <= cmd_d;
      cmd_valid_q <= cmd_valid_d;
    end
  end
  assign cmd_q = cmd_r_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_ready = (st_q == spd_pkg::ST_RUN);
  assign power_down = !cke;
  assign buffers_off = (st_q == spd_pkg::ST_HOLD) || (st_q == spd_pkg::ST_DOWN);
  assign receivers_off = (st_q == spd_pkg::ST_DOWN);
  // internal work must finish first
  assign low_current = buffers_off && !ctrl_q[spd_pkg::CTRL_OPS_BUSY_BIT];
  assign refresh_run = buffers_off && ctrl_q[spd_pkg::CTRL_SELF_REFRESH_BIT];
  assign ca_term_on = (term_q[spd_pkg::TERM_HI:spd_pkg::TERM_LO] != 3'h0)
    && ctrl_q[spd_pkg::CTRL_EXT_TERM_BIT]
    && ctrl_q[spd_pkg::CTRL_IO_SUPPLY_OK_BIT];
  assign status_w = {23'h000000, ca_term_on, low_current, var_q, st_q};
endmodule : spd_power_down
`default_nettype wire

// ### bench/spd_power_down_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module spd_power_down_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cke_pin,
  input wire logic power_down,
  input wire logic buffers_off,
  input wire logic receivers_off,
  input wire logic low_current,
  input wire logic refresh_run,
  input wire logic cmd_ready,
  input wire logic cmd_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====
  // saturating count of cycles with buffers off
  logic [3:0] held_q;
  logic [3:0] held_d;
  always_comb held_d = !buffers_off ? 4'h0 : held_q + {3'h0, held_q != 4'hf};
  always_ff @(posedge clk_sys) held_q <= rstn ? held_d : 4'h0;
  sequence s_fall; cke_pin ##1 !cke_pin [*3]; endsequence
  sequence s_rise; !cke_pin ##1 cke_pin [*3]; endsequence
  a_enter_async:
    assert property (s_fall |-> power_down) else $error("power_down late");
  a_buf_off:
    assert property (s_fall |-> ##[0:2] buffers_off) else $error("buffers still on");
  a_recv_hold:
    assert property ($rose(receivers_off) |-> held_q >= 4'h5) else $error("receivers off early");
  a_exit_async:
    assert property (s_rise |-> !power_down) else $error("power_down stuck");
  a_exit_wait:
    assert property ($fell(receivers_off) |-> !cmd_ready [*5]) else $error("ready too soon");
  a_down_quiet:
    assert property (receivers_off |-> !cmd_valid) else $error("command taken while down");
  a_cmd_gate:
    assert property (cmd_valid |-> $past(cmd_ready)) else $error("command before ready");
  a_lowcur_gate:
    assert property (low_current |-> buffers_off) else $error("low current while up");
  a_refresh_sr:
    assert property (refresh_run |-> buffers_off) else $error("refresh flag while up");
endmodule : spd_power_down_asserts
`default_nettype wire

// ### bench/spd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module spd_ctrl_model (
  output var logic cke_pin,
  output var logic ck_pin,
  output var logic cs_pin,
  output var logic [5:0] command_address_bus
);
  logic ck_run;
  // ====
  // link clock, parks low when stopped
  initial begin
    cke_pin = 1'h1;
    ck_pin = 1'h0;
    cs_pin = 1'h0;
    command_address_bus = 6'h2a;
    ck_run = 1'h1;
    #37;
    forever begin
      #160;
      if (ck_run || ck_pin) ck_pin = ~ck_pin;
    end
  end
  // no read, write or mode access is ever left running at entry
  task automatic enter_pd;
    @(negedge ck_pin);
    cs_pin = 1'h0;
    cke_pin = 1'h0;
    repeat (5) @(posedge ck_pin);
  endtask : enter_pd
  task automatic leave_pd;
    ck_run = 1'h1;
    repeat (3) @(posedge ck_pin);
    @(negedge ck_pin);
    cke_pin = 1'h1;
    repeat (5) @(posedge ck_pin);
  endtask : leave_pd
  task automatic issue(input logic [5:0] cmd);
    @(negedge ck_pin);
    cs_pin = 1'h1;
    command_address_bus = cmd;
    @(negedge ck_pin);
    cs_pin = 1'h0;
    // deselected bus must not keep showing the command
    command_address_bus = ~cmd;
  endtask : issue
endmodule : spd_ctrl_model
`default_nettype wire

// ### bench/spd_power_down_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module spd_power_down_tb_top;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [2:0] term;
    logic [2:0] vr;
    logic lc;
    logic rr;
    logic ct;
  } spd_row_t;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic cke_pin, ck_pin, cs_pin, power_down, buffers_off, receivers_off, low_current;
  logic refresh_run, ca_term_on, cmd_ready, cmd_valid, s_axi_rvalid;
  logic [5:0] command_address_bus, cmd_q, last_cmd, pins;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] n_cmd = 8'h0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  spd_row_t r;
  spd_row_t rows [7] = '{'{5'h00, 3'h0, 3'h2, 1'h1, 1'h0, 1'h0},
    '{5'h01, 3'h1, 3'h4, 1'h1, 1'h0, 1'h0}, '{5'h02, 3'h0, 3'h1, 1'h1, 1'h1, 1'h0},
    '{5'h05, 3'h0, 3'h4, 1'h0, 1'h0, 1'h0}, '{5'h18, 3'h6, 3'h2, 1'h1, 1'h0, 1'h1},
    '{5'h10, 3'h7, 3'h2, 1'h1, 1'h0, 1'h0}, '{5'h08, 3'h3, 3'h2, 1'h1, 1'h0, 1'h0}};
  assign pins = {power_down, buffers_off, receivers_off, low_current, refresh_run, ca_term_on};
  always #20 clk_sys = ~clk_sys;
  spd_ctrl_model ctl (.cke_pin, .ck_pin, .cs_pin, .command_address_bus);
  spd_power_down uut (.clk_sys, .rstn, .cke_pin, .ck_pin, .cs_pin, .command_address_bus,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_down,
    .buffers_off, .receivers_off, .low_current, .refresh_run, .ca_term_on, .cmd_ready,
    .cmd_q, .cmd_valid);
  // ====
  // bus access, one transfer at a time
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic at, wt, rt, done;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    done = 1'h0;
    while (!done) begin
      @(negedge clk_sys);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      rt = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      resp = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk_sys);
      if (at) s_axi_awvalid <= 1'h0;
      if (wt) s_axi_wvalid <= 1'h0;
      if (rt) s_axi_arvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask : axi
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_hi(input logic sel);
    for (int k = 0; k < 80 && (sel ? receivers_off : cmd_ready) !== 1'h1; k++) @(negedge clk_sys);
  endtask : wait_hi
  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'h1) begin
      n_cmd <= n_cmd + 8'h1;
      last_cmd <= cmd_q;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      axi(1'h1, spd_pkg::ADDR_CTRL, 32'(r.ctrl));
      axi(1'h1, spd_pkg::ADDR_TERM, 32'({r.term, 4'h0}));
      ctl.enter_pd();
      wait_hi(1'h1);
      // stopping the link clock while down is legal
      ctl.ck_run = 1'h0;
      chk("down", 32'({3'h7, r.lc, r.rr, r.ct}), 32'(pins));
      axi(1'h0, spd_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'({r.ct, r.lc, r.vr, spd_pkg::ST_DOWN}), rd);
      ctl.leave_pd();
      wait_hi(1'h0);
      chk("up", 32'h1, 32'({pins[5:1], cmd_ready}));
      ctl.issue(6'h11 + 6'(i));
      @(negedge clk_sys);
      chk("cmd", 32'({8'(i + 1), 6'h11 + 6'(i)}), 32'({n_cmd, last_cmd}));
    end
    ctl.enter_pd();
    wait_hi(1'h1);
    ctl.issue(6'h3f);
    @(negedge clk_sys);
    chk("ignored", 32'h7, 32'(n_cmd));
    ctl.leave_pd();
    wait_hi(1'h0);
    axi(1'h1, 4'hc, 32'h0);
    chk("wr unmapped", 32'(spd_pkg::RESP_SLVERR), 32'(resp));
    axi(1'h0, 4'hc, 32'h0);
    chk("rd unmapped", 32'({spd_pkg::RESP_SLVERR, 30'h0}), {resp, rd[29:0]});
    axi(1'h1, spd_pkg::ADDR_STATUS, 32'hffff_ffff);
    axi(1'h0, spd_pkg::ADDR_STATUS, 32'h0);
    chk("status ro", 32'({spd_pkg::RESP_OKAY, spd_pkg::ST_RUN}), 32'({resp, rd[3:0]}));
    axi(1'h1, spd_pkg::ADDR_CTRL, 32'h1f);
    axi(1'h1, spd_pkg::ADDR_TERM, 32'h70);
    rstn <= 1'h0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (4) @(negedge clk_sys);
    chk("reset pins", 32'h1, 32'({pins, cmd_ready}));
    axi(1'h0, spd_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", spd_pkg::CTRL_RESET, rd);
    axi(1'h0, spd_pkg::ADDR_TERM, 32'h0);
    chk("term reset", spd_pkg::TERM_RESET, rd);
    print_verdict();
  end
endmodule : spd_power_down_tb_top
bind spd_power_down spd_power_down_asserts u_chk (.clk_sys, .rstn, .cke_pin, .power_down,
  .buffers_off, .receivers_off, .low_current, .refresh_run, .cmd_ready, .cmd_valid);
`default_nettype wire
